/* File: bench/irs_pin_model.sv */
// Source model of the external request pin
`timescale 1ns/1ps
module irs_pin_model (
    // Clock and command
    input  wire logic ref_clk_in,
    input  wire logic level_in,
    // Pin
    output logic      pin_out
);
    // Pin changes only just after a clock edge
    always_ff @(posedge ref_clk_in) begin
        pin_out <= level_in;
    end
endmodule // irs_pin_model

/* File: bench/irs_properties.sv */
// Checker on the ports of the configuration register block
`timescale 1ns/1ps
module irs_properties (
    // Clock and reset
    input wire logic        ref_clk_in,
    input wire logic        resetn_in,
    // Register port
    input wire logic [7:0]  addr_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [7:0]  rdata_out,
    // Pin and instruction side
    input wire logic        pullup_en_out,
    input wire logic        pulldown_en_out,
    input wire logic        request_irq_out,
    input wire logic        background_instr_in,
    input wire logic        background_mode_enable_in,
    input wire logic        illegal_opcode_reset_out,
    // Watchdog side
    input wire logic        watchdog_restart_out,
    input wire logic        watchdog_enable_out,
    input wire logic [18:0] watchdog_period_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    property p_req_rd;
        $past(rd_in && addr_in == irs_pkg::ADDR_REQ_CTRL) |-> rdata_out[7:6] == 2'h0 && !rdata_out[2];
    endproperty
    a_req_rd: assert property (p_req_rd) else $error("Request read shows a zero bit set");
    property p_rst_rd;
        $past(rd_in && addr_in == irs_pkg::ADDR_RST_STAT) |-> !rdata_out[3] && !rdata_out[0];
    endproperty
    a_rst_rd: assert property (p_rst_rd) else $error("Reset status zero bits set");
    property p_restart;
        watchdog_restart_out == $past(wr_in && addr_in == irs_pkg::ADDR_RST_STAT);
    endproperty
    a_restart: assert property (p_restart) else $error("Watchdog restart mismatch");
    property p_period;
        watchdog_period_out == irs_pkg::WDOG_LONG_CYCLES || watchdog_period_out == irs_pkg::WDOG_SHORT_CYCLES;
    endproperty
    a_period: assert property (p_period) else $error("Watchdog period illegal");
    property p_background_instruction;
        background_instr_in && !background_mode_enable_in |-> illegal_opcode_reset_out;
    endproperty
    a_background_instruction: assert property (p_background_instruction) else $error("Background opcode not illegal");
    property p_irq_fall;
        $fell(request_irq_out) |-> $past(wr_in);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("Interrupt dropped without a write");
    property p_opt;
        $changed({watchdog_enable_out, watchdog_period_out}) |-> $past(wr_in && addr_in == irs_pkg::ADDR_SYS_OPT);
    endproperty
    a_opt: assert property (p_opt) else $error("Options changed without a write");
    property p_pull;
        !(pullup_en_out && pulldown_en_out) && (!$changed({pullup_en_out, pulldown_en_out}) || $past(wr_in));
    endproperty
    a_pull: assert property (p_pull) else $error("Pull resistor select wrong");
endmodule // irs_properties
bind irs_top irs_properties i_props (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pullup_en_out(pullup_en_out),
    .pulldown_en_out(pulldown_en_out), .request_irq_out(request_irq_out),
    .background_instr_in(background_instr_in), .background_mode_enable_in(background_mode_enable_in),
    .illegal_opcode_reset_out(illegal_opcode_reset_out), .watchdog_restart_out(watchdog_restart_out),
    .watchdog_enable_out(watchdog_enable_out), .watchdog_period_out(watchdog_period_out));

/* File: bench/irs_top_bench.sv */
// Self-checking bench for the request, reset status and options registers
`timescale 1ns/1ps
module irs_top_bench;
    localparam logic [7:0] RQ = irs_pkg::ADDR_REQ_CTRL;
    localparam logic [7:0] RS = irs_pkg::ADDR_RST_STAT;
    localparam logic [7:0] OP = irs_pkg::ADDR_SYS_OPT;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        lvl = 1'b1;
    logic [6:0]  cause = 7'h00;
    logic        stop = 1'b0;
    logic        background_instruction = 1'b0;
    logic        bme = 1'b1;
    logic [7:0]  rdata;
    logic        pin, pu, pd, irq, illegal_opcode_flag, rwd, wden;
    logic [18:0] per;
    int          fails = 0;
    int          cmp_count = 0;
    always #5 clk = ~clk;
    irs_pin_model i_pin (.ref_clk_in(clk), .level_in(lvl), .pin_out(pin));
    irs_top i_dut (.ref_clk_in(clk), .resetn_in(rstn), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .request_pin_in(pin), .pullup_en_out(pu), .pulldown_en_out(pd),
        .request_irq_out(irq), .por_cause_in(cause[6]), .pin_cause_in(cause[5]), .wdog_cause_in(cause[4]),
        .illegal_opcode_flag_cause_in(cause[3]), .clkgen_cause_in(cause[2]), .lv_cause_in(cause[1]),
        .debug_force_cause_in(cause[0]), .stop_instr_in(stop), .background_instr_in(background_instruction),
        .background_mode_enable_in(bme), .illegal_opcode_reset_out(illegal_opcode_flag), .watchdog_restart_out(rwd),
        .watchdog_enable_out(wden), .watchdog_period_out(per));
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("read data", {11'h0, exp}, {11'h0, rdata});
    endtask
    task automatic do_reset(input logic [6:0] c);
        @(posedge clk);
        cause <= c;
        rstn <= 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        cause <= 7'h00;
    endtask
    task automatic pin_set(input logic v);
        @(posedge clk);
        lvl <= v;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        stop_test;
    end
    initial begin
        logic [6:0] cs [5] = '{7'h24, 7'h40, 7'h02, 7'h21, 7'h18};
        logic [7:0] ex [5] = '{8'h44, 8'h82, 8'h82, 8'h00, 8'h30};
        for (int i = 0; i < 5; i++) begin
            do_reset(cs[i]);
            rd8(RS, ex[i]);
        end
        wr8(RS, 8'hff);
        chk("restart", 19'h1, {18'h0, rwd});
        rd8(RS, 8'h30);
        rd8(OP, 8'hc0);
        chk("period", irs_pkg::WDOG_LONG_CYCLES, per);
        @(posedge clk);
        stop <= 1'b1;
        #1;
        chk("stop", 19'h1, {18'h0, illegal_opcode_flag});
        wr8(OP, 8'h20);
        chk("stop", 19'h0, {18'h0, illegal_opcode_flag});
        chk("wd en", 19'h0, {18'h0, wden});
        chk("period", irs_pkg::WDOG_SHORT_CYCLES, per);
        wr8(OP, 8'he0);
        rd8(OP, 8'h20);
        @(posedge clk);
        stop <= 1'b0;
        background_instruction <= 1'b1;
        bme <= 1'b0;
        rd8(8'h05, 8'h00);
        chk("background_instruction", 19'h1, {18'h0, illegal_opcode_flag});
        wr8(RQ, 8'h12);
        chk("pulls", 19'h2, {17'h0, pu, pd});
        pin_set(1'b0);
        rd8(RQ, 8'h1a);
        chk("irq", 19'h1, {18'h0, irq});
        wr8(RQ, 8'h16);
        rd8(RQ, 8'h12);
        wr8(RQ, 8'h13);
        wr8(RQ, 8'h17);
        rd8(RQ, 8'h1b);
        pin_set(1'b1);
        wr8(RQ, 8'h17);
        rd8(RQ, 8'h13);
        wr8(RQ, 8'h39);
        chk("pulls", 19'h1, {17'h0, pu, pd});
        rd8(RQ, 8'h39);
        chk("irq", 19'h0, {18'h0, irq});
        wr8(RQ, 8'h00);
        wr8(RQ, 8'h04);
        pin_set(1'b0);
        pin_set(1'b1);
        rd8(RQ, 8'h00);
        stop_test;
    end
endmodule // irs_top_bench

/* File: include/irs_pkg.sv */
// Package with register map, field positions, reset values and watchdog counts
package irs_pkg;
    // Register offsets on the plain register port
    localparam logic [7:0] ADDR_REQ_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_RST_STAT  = 8'h01;
    localparam logic [7:0] ADDR_SYS_OPT   = 8'h02;

    // Request status and control fields
    localparam int REQ_POL_BIT    = 5;
    localparam int REQ_PE_BIT     = 4;
    localparam int REQ_FLAG_BIT   = 3;
    localparam int REQ_ACK_BIT    = 2;
    localparam int REQ_IE_BIT     = 1;
    localparam int REQ_MODE_BIT   = 0;

    // Reset status fields
    localparam int RST_POR_BIT    = 7;
    localparam int RST_PIN_BIT    = 6;
    localparam int RST_WDOG_BIT   = 5;
    localparam int RST_ILLEGAL_OPCODE_FLAG_BIT   = 4;
    localparam int RST_CLKGEN_BIT = 2;
    localparam int RST_LV_BIT     = 1;

    // System options fields
    localparam int OPT_WDOG_EN_BIT  = 7;
    localparam int OPT_WDOG_PER_BIT = 6;
    localparam int OPT_STOP_EN_BIT  = 5;

    // Reset values
    localparam logic       REQ_POL_RST    = 1'b0;
    localparam logic       REQ_PE_RST     = 1'b0;
    localparam logic       REQ_IE_RST     = 1'b0;
    localparam logic       REQ_MODE_RST   = 1'b0;
    localparam logic       WDOG_EN_RST    = 1'b1;
    localparam logic       WDOG_PER_RST   = 1'b1;
    localparam logic       STOP_EN_RST    = 1'b0;
    localparam logic       PIN_PREV_RST   = 1'b1;

    // Watchdog timeout lengths in bus clock cycles
    localparam int         WDOG_SHORT_LOG2 = 13;
    localparam int         WDOG_LONG_LOG2  = 18;
    localparam logic [18:0] WDOG_SHORT_CYCLES = 19'h02000;
    localparam logic [18:0] WDOG_LONG_CYCLES  = 19'h40000;
endpackage

/* File: logic/irs_top.sv */
// System configuration registers: request pin detector, reset status and write-once options
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module irs_top (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        resetn_in,
    // Register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out,
    // External request pin
    input  wire logic        request_pin_in,
    output logic             pullup_en_out,
    output logic             pulldown_en_out,
    output logic             request_irq_out,
    // Reset causes, held stable by the reset controller across reset release
    input  wire logic        por_cause_in,
    input  wire logic        pin_cause_in,
    input  wire logic        wdog_cause_in,
    input  wire logic        illegal_opcode_flag_cause_in,
    input  wire logic        clkgen_cause_in,
    input  wire logic        lv_cause_in,
    input  wire logic        debug_force_cause_in,
    // Instruction decode
    input  wire logic        stop_instr_in,
    input  wire logic        background_instr_in,
    input  wire logic        background_mode_enable_in,
    output logic             illegal_opcode_reset_out,
    // Watchdog control
    output logic             watchdog_restart_out,
    output logic             watchdog_enable_out,
    output logic      [18:0] watchdog_period_out
);

    // Reset synchroniser
    logic       rst_meta_q;
    logic       rst_sync_q;
    logic       rstn;

    // Register state
    logic       pol_q;
    logic       pe_q;
    logic       flag_q;
    logic       flag_d;
    logic       ie_q;
    logic       mode_q;
    logic       pin_prev_q;
    logic [7:0] rst_stat_q;
    logic       capture_q;
    logic       wdog_en_q;
    logic       wdog_per_q;
    logic       stop_en_q;
    logic       opt_locked_q;
    logic [7:0] rdata_q;
    logic       restart_q;

    // Decode
    logic       wr_req;
    logic       wr_rst;
    logic       wr_opt;
    logic       pin_asserted;
    logic       prev_asserted;
    logic       edge_seen;
    logic       event_seen;
    logic       ack;

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign rstn = rst_sync_q;

    assign wr_req = wr_in && (addr_in == irs_pkg::ADDR_REQ_CTRL);
    assign wr_rst = wr_in && (addr_in == irs_pkg::ADDR_RST_STAT);
    assign wr_opt = wr_in && (addr_in == irs_pkg::ADDR_SYS_OPT);

    // Request control bits
    always_ff @(posedge ref_clk_in or negedge rstn) begin
        if (!rstn) begin
            pol_q  <= irs_pkg::REQ_POL_RST;
            pe_q   <= irs_pkg::REQ_PE_RST;
            ie_q   <= irs_pkg::REQ_IE_RST;
            mode_q <= irs_pkg::REQ_MODE_RST;
        end else if (wr_req) begin
            pol_q  <= wdata_in[irs_pkg::REQ_POL_BIT];
            pe_q   <= wdata_in[irs_pkg::REQ_PE_BIT];
            ie_q   <= wdata_in[irs_pkg::REQ_IE_BIT];
            mode_q <= wdata_in[irs_pkg::REQ_MODE_BIT];
        end
    end

    // Event detection on the request pin
    assign pin_asserted  = (request_pin_in == pol_q);
    assign prev_asserted = (pin_prev_q == pol_q);
    assign edge_seen     = pin_asserted && !prev_asserted;
    assign event_seen    = pe_q && (edge_seen || (mode_q && pin_asserted));
    assign ack           = wr_req && wdata_in[irs_pkg::REQ_ACK_BIT];

    always_comb begin
        flag_d = flag_q;
        if (ack) begin
            flag_d = 1'b0;
        end
        if (event_seen) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn) begin
        if (!rstn) begin
            flag_q     <= 1'b0;
            pin_prev_q <= irs_pkg::PIN_PREV_RST;
        end else begin
            flag_q     <= flag_d;
            pin_prev_q <= request_pin_in;
        end
    end

    assign request_irq_out = flag_q && ie_q;
    assign pullup_en_out   = pe_q && !pol_q;
    assign pulldown_en_out = pe_q && pol_q;

    // Reset status is captured once after reset release
    always_ff @(posedge ref_clk_in or negedge rstn) begin
        if (!rstn) begin
            capture_q <= 1'b1;
        end else begin
            capture_q <= 1'b0;
        end
    end

    // Kept without reset so that a low-voltage reset leaves the power-on flag alone
    always_ff @(posedge ref_clk_in) begin
        if (capture_q) begin
            if (debug_force_cause_in) begin
                rst_stat_q <= 8'h00;
            end else if (por_cause_in) begin
                rst_stat_q <= 8'h00;
                rst_stat_q[irs_pkg::RST_POR_BIT] <= 1'b1;
                rst_stat_q[irs_pkg::RST_LV_BIT]  <= 1'b1;
            end else if (lv_cause_in) begin
                rst_stat_q[6:0] <= 7'h00;
                rst_stat_q[irs_pkg::RST_LV_BIT] <= 1'b1;
            end else begin
                rst_stat_q <= 8'h00;
                rst_stat_q[irs_pkg::RST_PIN_BIT]    <= pin_cause_in;
                rst_stat_q[irs_pkg::RST_WDOG_BIT]   <= wdog_cause_in;
                rst_stat_q[irs_pkg::RST_ILLEGAL_OPCODE_FLAG_BIT]   <= illegal_opcode_flag_cause_in;
                rst_stat_q[irs_pkg::RST_CLKGEN_BIT] <= clkgen_cause_in;
            end
        end
    end

    // Any write to the status address restarts the watchdog
    always_ff @(posedge ref_clk_in or negedge rstn) begin
        if (!rstn) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= wr_rst;
        end
    end

    assign watchdog_restart_out = restart_q;

    // Write-once system options
    always_ff @(posedge ref_clk_in or negedge rstn) begin
        if (!rstn) begin
            wdog_en_q    <= irs_pkg::WDOG_EN_RST;
            wdog_per_q   <= irs_pkg::WDOG_PER_RST;
            stop_en_q    <= irs_pkg::STOP_EN_RST;
            opt_locked_q <= 1'b0;
        end else if (wr_opt && !opt_locked_q) begin
            wdog_en_q    <= wdata_in[irs_pkg::OPT_WDOG_EN_BIT];
            wdog_per_q   <= wdata_in[irs_pkg::OPT_WDOG_PER_BIT];
            stop_en_q    <= wdata_in[irs_pkg::OPT_STOP_EN_BIT];
            opt_locked_q <= 1'b1;
        end
    end

    assign watchdog_enable_out = wdog_en_q;
    assign watchdog_period_out = wdog_per_q ? irs_pkg::WDOG_LONG_CYCLES
                                            : irs_pkg::WDOG_SHORT_CYCLES;

    assign illegal_opcode_reset_out = (stop_instr_in && !stop_en_q) ||
                                      (background_instr_in && !background_mode_enable_in);

    // Read data, one cycle after the read strobe
    always_ff @(posedge ref_clk_in or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                irs_pkg::ADDR_REQ_CTRL: begin
                    rdata_q <= {2'b00, pol_q, pe_q, flag_q, 1'b0, ie_q, mode_q};
                end
                irs_pkg::ADDR_RST_STAT: begin
                    rdata_q <= {rst_stat_q[7:4], 1'b0, rst_stat_q[2:1], 1'b0};
                end
                irs_pkg::ADDR_SYS_OPT: begin
                    rdata_q <= {wdog_en_q, wdog_per_q, stop_en_q, 5'h00};
                end
                default: begin
                    rdata_q <= 8'h00;
                end
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata_out = rdata_q;

endmodule // irs_top
